// *** src/limit_alert_map.svh ***
// register offsets, field positions, reset values and sample counts
// assumes byte-wide register addresses from the management port decoder
`ifndef LIMIT_ALERT_MAP_SVH
`define LIMIT_ALERT_MAP_SVH

`define UNDERVOLTAGE_THR_BASE 8'h40
`define UNDERVOLTAGE_THR_LAST 8'h43
`define OVERCURRENT_COUNT_ADDR 8'h44
`define UNDERVOLTAGE_THR_RESET 16'h0000
`define OVERCURRENT_COUNT_RESET 8'h00
`define OVERCURRENT_CH1_LSB 6
`define OVERCURRENT_CH2_LSB 4
`define OVERCURRENT_CH3_LSB 2
`define OVERCURRENT_CH4_LSB 0
`define OVERCURRENT_FIELD_WIDTH 2
`define OVERCURRENT_SAMPLES_CODE0 5'h01
`define OVERCURRENT_SAMPLES_CODE1 5'h04
`define OVERCURRENT_SAMPLES_CODE2 5'h08
`define OVERCURRENT_SAMPLES_CODE3 5'h10
`define UNMAPPED_READ 16'h0000

`endif

// *** src/limit_alert_pkg.sv ***
// types shared by the limit qualifier and its top
// assumes the constants live in limit_alert_map.svh
package limit_alert_pkg;
  typedef logic signed [15:0] result_t;
  typedef logic [1:0] sample_code_t;
  typedef logic [1:0] channel_t;
  typedef enum logic [2:0] {
    ST_CLEAR = 3'b001,
    ST_COUNT = 3'b010,
    ST_WARN = 3'b100
  } qual_state_e;
endpackage

// *** src/overcurrent_qualifier.sv ***
// one channel of the consecutive-sample overcurrent qualifier
// assumes sample is a one-cycle pulse per completed conversion of this channel
`timescale 1ns/1ps
`include "limit_alert_map.svh"

module overcurrent_qualifier (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sample,
  input wire logic over,
  input wire limit_alert_pkg::sample_code_t code,
  output logic warn
);
  import limit_alert_pkg::*;

  qual_state_e state_q;
  qual_state_e state_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [4:0] need;
  logic [4:0] cnt_inc;
  logic warn_q;
  logic warn_d;

  ////////////////////////////////////////////////////////////////
  // decode count field
  always_comb begin
    case (code)
      2'b00: need = `OVERCURRENT_SAMPLES_CODE0;
      2'b01: need = `OVERCURRENT_SAMPLES_CODE1;
      2'b10: need = `OVERCURRENT_SAMPLES_CODE2;
      default: need = `OVERCURRENT_SAMPLES_CODE3;
    endcase
  end

  // saturate so a long run cannot wrap back below the limit
  assign cnt_inc = (cnt_q == `OVERCURRENT_SAMPLES_CODE3) ? cnt_q : cnt_q + 5'h01;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (sample) begin
      if (over) begin
        case (state_q)
          ST_CLEAR, ST_COUNT: begin
            cnt_d = cnt_inc;
            state_d = (cnt_inc >= need) ? ST_WARN : ST_COUNT;
          end
          ST_WARN: state_d = ST_WARN;
          default: state_d = ST_CLEAR;
        endcase
      end else begin
        cnt_d = 5'h00;
        state_d = ST_CLEAR;
      end
    end
    // warning leaves the block from its own flop
    warn_d = (state_d == ST_WARN);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_CLEAR;
      cnt_q <= 5'h00;
      warn_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      warn_q <= warn_d;
    end
  end

  assign warn = warn_q;

  ////////////////////////////////////////////////////////////////
  a_warn_needs_run: assert property (@(posedge clk) disable iff (!rstn)
    $rose(warn) |-> $past(sample) && $past(over) && ($past(cnt_inc) >= $past(need)))
    else $error("warning raised before the run reached the count");

  a_clean_clears_warn: assert property (@(posedge clk) disable iff (!rstn)
    sample && !over |=> !warn && (cnt_q == 5'h00))
    else $error("clean sample did not clear warning and count");

  a_run_restart: assert property (@(posedge clk) disable iff (!rstn)
    !warn && sample && !over ##1 sample && over && (need > 5'h01) |=> !warn && (cnt_q == 5'h01))
    else $error("run did not restart after a clean sample");

  a_hold_while_warn: assert property (@(posedge clk) disable iff (!rstn)
    warn && !(sample && !over) |=> warn && $stable(cnt_q))
    else $error("raised warning or its counter moved without a clean sample");

  a_single_sample: assert property (@(posedge clk) disable iff (!rstn)
    sample && over && (code == 2'b00) |=> warn)
    else $error("single-sample setting did not raise at once");

  a_sixteen_needed: assert property (@(posedge clk) disable iff (!rstn)
    sample && over && !warn && (code == 2'b11) && (cnt_q == 5'h0e) |=> !warn && (cnt_q == 5'h0f))
    else $error("sixteen-sample setting raised early");
endmodule

// *** src/limit_alert_qualifier.sv ***
// undervoltage thresholds and overcurrent sample qualifier, four channels
// assumes a same-clock register port from the management bus decoder
// and a one-cycle conversion strobe with channel, result and over-limit level
//
// How it works
// - each channel holds its own 16-bit undervoltage threshold
// - thresholds are signed two's complement in every measurement mode
// - channel 1 threshold at 40h, channels 2..4 follow up to 43h
// - a write to one threshold leaves the other channels untouched
// - overcurrent warning needs the programmed run of consecutive over-limit conversions
// - after reset the sample-count setting is 00, one sample
// - once raised the counter holds until a clean conversion completes
// - a single clean conversion clears a raised warning
// - channel 1 count field bits 7-6: 00=1, 01=4, 10=8, 11=16
// - channels 2,3,4 fields at bits 5-4, 3-2, 1-0, same decode
`timescale 1ns/1ps
`include "limit_alert_map.svh"

module limit_alert_qualifier #(
  parameter int CHANNELS = 4
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  input wire logic CONV_DONE,
  input wire limit_alert_pkg::channel_t CONV_CH,
  input wire limit_alert_pkg::result_t CONV_RESULT,
  input wire logic CONV_OVER,
  output logic [CHANNELS-1:0] UNDERVOLTAGE_FLAG,
  output logic [CHANNELS-1:0] OVERCURRENT_WARN
);
  import limit_alert_pkg::*;

  result_t thr_q [CHANNELS];
  result_t thr_d [CHANNELS];
  logic [7:0] count_cfg_q;
  logic [7:0] count_cfg_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [CHANNELS-1:0] under_q;
  logic [CHANNELS-1:0] under_d;
  logic written_q;
  logic written_d;

  ////////////////////////////////////////////////////////////////
  // register writes
  always_comb begin
    for (int k = 0; k < CHANNELS; k++) begin
      thr_d[k] = thr_q[k];
      if (REG_WR && (REG_ADDR == `UNDERVOLTAGE_THR_BASE + 8'(k)))
        thr_d[k] = REG_WDATA;
    end
    count_cfg_d = count_cfg_q;
    if (REG_WR && (REG_ADDR == `OVERCURRENT_COUNT_ADDR))
      count_cfg_d = REG_WDATA[7:0];
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int k = 0; k < CHANNELS; k++)
        thr_q[k] <= `UNDERVOLTAGE_THR_RESET;
      count_cfg_q <= `OVERCURRENT_COUNT_RESET;
    end else begin
      for (int k = 0; k < CHANNELS; k++)
        thr_q[k] <= thr_d[k];
      count_cfg_q <= count_cfg_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // register reads, registered; unmapped addresses read zero
  // a read and a write in one cycle return the old value
  always_comb begin
    rdata_d = rdata_q;
    if (REG_RD) begin
      rdata_d = `UNMAPPED_READ;
      for (int k = 0; k < CHANNELS; k++)
        if (REG_ADDR == `UNDERVOLTAGE_THR_BASE + 8'(k))
          rdata_d = thr_q[k];
      if (REG_ADDR == `OVERCURRENT_COUNT_ADDR)
        rdata_d = {8'h00, count_cfg_q};
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN)
      rdata_q <= `UNMAPPED_READ;
    else
      rdata_q <= rdata_d;
  end

  assign REG_RDATA = rdata_q;

  ////////////////////////////////////////////////////////////////
  // undervoltage compare, refreshed on each conversion of the channel
  // equal to the threshold does not flag
  always_comb begin
    under_d = under_q;
    for (int k = 0; k < CHANNELS; k++)
      if (CONV_DONE && (CONV_CH == channel_t'(k)))
        under_d[k] = (CONV_RESULT < thr_q[k]);
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN)
      under_q <= '0;
    else
      under_q <= under_d;
  end

  assign UNDERVOLTAGE_FLAG = under_q;

  ////////////////////////////////////////////////////////////////
  // overcurrent qualifiers; a rewrite of the count mid-run is not
  // guarded here, the host masks warnings around it
  for (genvar k = 0; k < CHANNELS; k++) begin : g_chan
    // channel 1 in the top field
    overcurrent_qualifier u_qual (
      .clk(CLK),
      .rstn(RSTN),
      .sample(CONV_DONE && (CONV_CH == channel_t'(k))),
      .over(CONV_OVER),
      .code(count_cfg_q[`OVERCURRENT_CH1_LSB - 2*k +: `OVERCURRENT_FIELD_WIDTH]),
      .warn(OVERCURRENT_WARN[k])
    );

    // per-channel checks
    a_warn_own_channel: assert property (@(posedge CLK) disable iff (!RSTN)
      $rose(OVERCURRENT_WARN[k]) |-> $past(CONV_DONE) && $past(CONV_OVER) && ($past(CONV_CH) == channel_t'(k)))
      else $error("warning raised without an over-limit conversion of its channel");

    a_flag_own_channel: assert property (@(posedge CLK) disable iff (!RSTN)
      CONV_DONE && (CONV_CH == channel_t'(k)) |=> UNDERVOLTAGE_FLAG[k] == ($past(CONV_RESULT) < $past(thr_q[k])))
      else $error("undervoltage flag of a channel does not follow its own threshold");
  end

  ////////////////////////////////////////////////////////////////
  // written flag only feeds the reset-value check below
  always_comb begin
    written_d = written_q;
    if (REG_WR && (REG_ADDR == `OVERCURRENT_COUNT_ADDR))
      written_d = 1'b1;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN)
      written_q <= 1'b0;
    else
      written_q <= written_d;
  end

  ////////////////////////////////////////////////////////////////
  // register map and output checks

  a_count_reset_value: assert property (@(posedge CLK) disable iff (!RSTN)
    !written_q |-> (count_cfg_q == 8'h00))
    else $error("sample count not at single-sample default");

  a_thr_write_ch1: assert property (@(posedge CLK) disable iff (!RSTN)
    REG_WR && (REG_ADDR == 8'h40) |=> thr_q[0] == $past(REG_WDATA))
    else $error("channel 1 threshold not written at 40h");

  a_thr_write_ch2: assert property (@(posedge CLK) disable iff (!RSTN)
    REG_WR && (REG_ADDR == 8'h41) |=> thr_q[1] == $past(REG_WDATA))
    else $error("channel 2 threshold not written at 41h");

  a_thr_write_ch3: assert property (@(posedge CLK) disable iff (!RSTN)
    REG_WR && (REG_ADDR == 8'h42) |=> thr_q[2] == $past(REG_WDATA))
    else $error("channel 3 threshold not written at 42h");

  a_thr_write_ch4: assert property (@(posedge CLK) disable iff (!RSTN)
    REG_WR && (REG_ADDR == 8'h43) |=> (thr_q[3] == $past(REG_WDATA)) && $stable(thr_q[0]))
    else $error("channel 4 threshold not written at 43h");

  a_thr_isolation: assert property (@(posedge CLK) disable iff (!RSTN)
    REG_WR && (REG_ADDR == 8'h41) |=> $stable(thr_q[0]) && $stable(thr_q[2]) && $stable(thr_q[3]))
    else $error("threshold write disturbed another channel");

  a_count_write: assert property (@(posedge CLK) disable iff (!RSTN)
    REG_WR && (REG_ADDR == 8'h44) |=> count_cfg_q == $past(REG_WDATA[7:0]))
    else $error("sample count register not written at 44h");

  a_count_isolation: assert property (@(posedge CLK) disable iff (!RSTN)
    REG_WR && (REG_ADDR != 8'h44) |=> $stable(count_cfg_q))
    else $error("sample count changed by a write elsewhere");

  a_read_threshold: assert property (@(posedge CLK) disable iff (!RSTN)
    REG_RD && (REG_ADDR == 8'h43) |=> REG_RDATA == $past(thr_q[3]))
    else $error("channel 4 threshold read back wrong");

  a_read_count: assert property (@(posedge CLK) disable iff (!RSTN)
    REG_RD && (REG_ADDR == 8'h44) |=> REG_RDATA == {8'h00, $past(count_cfg_q)})
    else $error("sample count read back wrong");

  a_read_unmapped: assert property (@(posedge CLK) disable iff (!RSTN)
    REG_RD && (REG_ADDR == 8'h45) |=> REG_RDATA == 16'h0000)
    else $error("address past the map did not read zero");

  a_uv_signed: assert property (@(posedge CLK) disable iff (!RSTN)
    CONV_DONE && (CONV_CH == 2'h0) |=>
      UNDERVOLTAGE_FLAG[0] == ($signed($past(CONV_RESULT)) < $signed($past(thr_q[0]))))
    else $error("undervoltage flag does not match signed compare");

  a_uv_quiet: assert property (@(posedge CLK) disable iff (!RSTN)
    !CONV_DONE |=> $stable(UNDERVOLTAGE_FLAG))
    else $error("undervoltage flag moved without a conversion");

  a_field_ch1: assert property (@(posedge CLK) disable iff (!RSTN)
    CONV_DONE && (CONV_CH == 2'h0) && CONV_OVER && (count_cfg_q[7:6] == 2'b00) |=> OVERCURRENT_WARN[0])
    else $error("channel 1 field not taken from bits 7-6");

  a_field_ch4: assert property (@(posedge CLK) disable iff (!RSTN)
    CONV_DONE && (CONV_CH == 2'h3) && CONV_OVER && (count_cfg_q[1:0] == 2'b00) |=> OVERCURRENT_WARN[3])
    else $error("channel 4 field not taken from bits 1-0");
endmodule

// *** verification/mgmt_host.sv ***
// host controller model on the register port of the limit qualifier
// assumes strobes sampled on rising clk and read data one cycle after the read strobe
`timescale 1ns/1ps
module mgmt_host (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'hff;
    reg_wdata = 16'hffff;
  end
  ////////////////////////////////////////
  // rewrites only with conversions idle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    // released lines show the inverse, not a stale copy
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the four-channel limit qualifier
// assumes the host model drives the register port and the bench drives conversions
`timescale 1ns/1ps
module testbench;
  import limit_alert_pkg::*;
  typedef struct {logic [7:0] addr; logic [15:0] wdata; logic [15:0] exp;} row_s;
  logic clk, rstn, reg_wr, reg_rd, conv_done, conv_over;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd;
  channel_t conv_ch;
  result_t conv_result;
  logic [3:0] undervoltage_flag, overcurrent_warn;
  int fails = 0;
  int tests_run = 0;
  int n;
  // 0x44 value 1b gives codes 00, 01, 10, 11 on channels 1..4
  row_s rows [6] = '{'{8'h40, 16'h8000, 16'h8000}, '{8'h41, 16'h7fff, 16'h7fff},
    '{8'h42, 16'h1234, 16'h1234}, '{8'h43, 16'hfffe, 16'hfffe},
    '{8'h44, 16'hab1b, 16'h001b}, '{8'h45, 16'h5555, 16'h0000}};
  mgmt_host mgmt_host_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  limit_alert_qualifier #(.CHANNELS(4)) limit_alert_qualifier_inst (.CLK(clk), .RSTN(rstn),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .CONV_DONE(conv_done), .CONV_CH(conv_ch), .CONV_RESULT(conv_result),
    .CONV_OVER(conv_over), .UNDERVOLTAGE_FLAG(undervoltage_flag), .OVERCURRENT_WARN(overcurrent_warn));
  ////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic conv(input channel_t ch, input result_t res, input logic ovr);
    @(posedge clk);
    conv_done <= 1'b1;
    conv_ch <= ch;
    conv_result <= res;
    conv_over <= ovr;
    @(posedge clk);
    conv_done <= 1'b0;
    conv_result <= ~res;
    conv_over <= ~ovr;
    #1;
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    fails++;
    complete_run();
  end
  initial begin
    rstn = 1'b0;
    conv_done = 1'b0;
    conv_ch = 2'h0;
    conv_result = 16'h0000;
    conv_over = 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    mgmt_host_inst.rd(8'h44, rd);
    check(rd, 16'h0000);
    mgmt_host_inst.rd(8'h43, rd);
    check(rd, 16'h0000);
    conv(2'h0, 16'sh0000, 1'b1);
    check({12'h000, overcurrent_warn}, 16'h0001);
    conv(2'h0, 16'sh0000, 1'b0);
    check({12'h000, overcurrent_warn}, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      mgmt_host_inst.wr(rows[i].addr, rows[i].wdata);
    end
    for (int i = 0; i < 6; i++) begin
      mgmt_host_inst.rd(rows[i].addr, rd);
      check(rd, rows[i].exp);
    end
    for (int c = 0; c < 4; c++) begin
      n = (c == 0) ? 1 : 2 << c;
      repeat (n - 1) conv(c[1:0], 16'sh0000, 1'b1);
      // a clean sample one short of the count restarts the run
      conv(c[1:0], 16'sh0000, 1'b0);
      repeat (n - 1) conv(c[1:0], 16'sh0000, 1'b1);
      check({12'h000, overcurrent_warn}, 16'h0000);
      conv(c[1:0], 16'sh0000, 1'b1);
      check({12'h000, overcurrent_warn}, 16'h0001 << c);
      conv(c[1:0], 16'sh0000, 1'b1);
      check({12'h000, overcurrent_warn}, 16'h0001 << c);
      conv(c[1:0], 16'sh0000, 1'b0);
      check({12'h000, overcurrent_warn}, 16'h0000);
    end
    // result 0 left channels 2 and 3 below their thresholds
    conv(2'h2, 16'sh1234, 1'b0);
    check({12'h000, undervoltage_flag}, 16'h0002);
    conv(2'h2, 16'sh1233, 1'b0);
    check({12'h000, undervoltage_flag}, 16'h0006);
    conv(2'h3, 16'shfffd, 1'b0);
    check({12'h000, undervoltage_flag}, 16'h000e);
    conv(2'h3, 16'sh0005, 1'b0);
    check({12'h000, undervoltage_flag}, 16'h0006);
    conv(2'h0, 16'sh8000, 1'b1);
    check({12'h000, undervoltage_flag, overcurrent_warn}, 16'h0061);
    // three over on channel 2, then clean and over back to back
    repeat (3) conv(2'h1, 16'sh7fff, 1'b1);
    @(posedge clk);
    conv_done <= 1'b1;
    conv_ch <= 2'h1;
    conv_result <= 16'sh7fff;
    conv_over <= 1'b0;
    @(posedge clk);
    conv_over <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    #1;
    check({12'h000, overcurrent_warn}, 16'h0001);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    #1;
    check({8'h00, undervoltage_flag, overcurrent_warn}, 16'h0000);
    @(posedge clk);
    rstn <= 1'b1;
    mgmt_host_inst.rd(8'h42, rd);
    check(rd, 16'h0000);
    mgmt_host_inst.rd(8'h44, rd);
    check(rd, 16'h0000);
    conv(2'h3, 16'sh0000, 1'b1);
    check({8'h00, undervoltage_flag, overcurrent_warn}, 16'h0008);
    complete_run();
  end
endmodule
